/* File: bench/scar_bank_sva.sv */
// Port checker for the security CAM address register bank.
`timescale 1ns/100ps
`default_nettype none
`include "scar_consts.vh"
module scar_bank_sva (
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic        clk_en,
    input wire logic [3:0]  reg_page,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [7:0]  reg_rdata,
    input wire logic        learn_enable,
    input wire logic        security_enable,
    input wire logic [31:0] shared_include,
    input wire logic [47:0] location1_addr,
    input wire logic [1:0]  location_valid
);
    // ****
    // Properties
    // ****
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    // Data write aimed at location one.
    wire wr_d1 = reg_write && reg_addr == `SCAR_ADDR_DATA1 && reg_page == `SCAR_PAGE_5;
    // Access to one of the shared valid registers.
    wire sv_hit = reg_page == `SCAR_PAGE_9 && reg_addr >= `SCAR_ADDR_SV1 && reg_addr <= `SCAR_ADDR_SV4;
    property p_cfg;
        clk_en && reg_write && reg_page == `SCAR_PAGE_4 && reg_addr == `SCAR_ADDR_CFG |=>
            learn_enable == $past(reg_wdata[0]) && security_enable == $past(reg_wdata[1]);
    endproperty
    a_cfg: assert property (p_cfg) else $error("config bits not loaded");
    property p_sec_off;
        clk_en && !security_enable |=> shared_include == `SCAR_VEC_ZERO;
    endproperty
    a_sec_off: assert property (p_sec_off) else $error("shared entries used");
    property p_keep;
        wr_d1 ##1 location_valid[0] [*2] |-> $stable(location1_addr);
    endproperty
    a_keep: assert property (p_keep) else $error("valid entry overwritten");
    property p_unmap;
        clk_en && reg_read && reg_page == 4'h7 |=> reg_rdata == `SCAR_BYTE_ZERO;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_rd_hold;
        !reg_read |=> $stable(reg_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_shared;
        clk_en && reg_write && sv_hit ##1 !reg_write ##1 clk_en && reg_read
            && reg_addr == $past(reg_addr, 2) && reg_page == $past(reg_page, 2)
            |=> reg_rdata == $past(reg_wdata, 3);
    endproperty
    a_shared: assert property (p_shared) else $error("shared valid readback");
    property p_vwr;
        clk_en && reg_write && reg_page == `SCAR_PAGE_4 && reg_addr == `SCAR_ADDR_INDEX
            ##1 clk_en |=> location_valid == {$past(reg_wdata[7], 2), $past(reg_wdata[3], 2)};
    endproperty
    a_vwr: assert property (p_vwr) else $error("valid flags not set");
    property p_zero;
        !location_valid[0] [*2] |-> location1_addr == `SCAR_ADDR_ZERO;
    endproperty
    a_zero: assert property (p_zero) else $error("invalid address shown");
    c_load: cover property (wr_d1 && location_valid[0]);
    c_sec: cover property (security_enable && shared_include != `SCAR_VEC_ZERO);
    c_both: cover property (location_valid == 2'h3);
endmodule
bind scar_bank scar_bank_sva u_sva (.sys_clk, .sys_rst, .clk_en, .reg_page, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .learn_enable, .security_enable, .shared_include,
    .location1_addr, .location_valid);
`default_nettype wire

/* File: bench/security_cam_address_registers_tb.sv */
// Self-checking bench for the security CAM address register bank.
`timescale 1ns/100ps
`default_nettype none
`include "scar_consts.vh"
module security_cam_address_registers_tb;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        clk_en = 1'b1;
    logic [3:0]  reg_page = 4'h0;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic        learn_strobe = 1'b0;
    logic [7:0]  learn_byte = 8'h00;
    wire  [7:0]  reg_rdata;
    wire         learn_enable;
    wire         security_enable;
    wire  [31:0] shared_include;
    wire  [47:0] loc1;
    wire  [47:0] loc2;
    wire  [1:0]  location_valid;
    logic [47:0] a1;
    logic [47:0] a2;
    logic [31:0] sv;
    logic [7:0]  rb;
    logic [3:0]  pg [4] = '{4'h5, 4'h6, 4'h8, 4'h9}; // Pages carrying the data register.
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          k;
    always #50 sys_clk = ~sys_clk;
    scar_bank DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_page(reg_page),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .learn_strobe(learn_strobe), .learn_byte(learn_byte),
        .reg_rdata(reg_rdata), .learn_enable(learn_enable), .security_enable(security_enable),
        .shared_include(shared_include), .location1_addr(loc1), .location2_addr(loc2),
        .location_valid(location_valid));
    // Compares one result, counting it.
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Expected image of the index register: valid and index of both locations.
    function automatic logic [7:0] idx_img(input logic v2, input logic [2:0] i2,
                                           input logic v1, input logic [2:0] i1);
        return {v2, i2, v1, i1};
    endfunction
    // One learned byte offered for a single cycle.
    task automatic lrn(input logic [7:0] b);
        @(negedge sys_clk);
        learn_byte = b;
        learn_strobe = 1'b1;
        @(negedge sys_clk);
        learn_strobe = 1'b0;
    endtask
    // One register write strobe.
    task automatic wr(input logic [3:0] p, input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_page = p;
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge sys_clk);
        reg_write = 1'b0;
    endtask
    // One register read; data is taken a cycle after the strobe.
    task automatic rd(input logic [3:0] p, input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        reg_page = p;
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge sys_clk);
        reg_read = 1'b0;
        d = reg_rdata;
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run;
        $display("Mismatches %0d of %0d comparisons", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Cuts a hang short.
    initial begin
        #2000000;
        n_mismatch++;
        complete_run;
    end
    // ****
    // Main sequence
    // ****
    initial begin
        k = $urandom(79);
        a1 = {16'($urandom), $urandom};
        a2 = {16'($urandom), $urandom};
        sv = $urandom | 32'h80000001;
        repeat (5) @(negedge sys_clk);
        sys_rst = 1'b0;
        rd(4'h4, `SCAR_ADDR_INDEX, rb);
        chk(48'(rb), 48'h0);
        // A frozen core ignores a configuration write and a data byte.
        @(negedge sys_clk);
        clk_en = 1'b0;
        wr(4'h4, `SCAR_ADDR_CFG, 8'h03);
        wr(4'h5, `SCAR_ADDR_DATA1, 8'h5a);
        @(negedge sys_clk);
        clk_en = 1'b1;
        rd(4'h4, `SCAR_ADDR_CFG, rb);
        chk(48'(rb), 48'h0);
        // With learning off, a learned byte is dropped and the index stays.
        lrn(8'h5a);
        rd(4'h4, `SCAR_ADDR_INDEX, rb);
        chk(48'(rb), 48'(idx_img(1'b0, 3'h0, 1'b0, 3'h0)));
        // Load location one over all data pages, index checked after each byte.
        for (k = 0; k < 6; k++) begin
            wr(pg[k % 4], `SCAR_ADDR_DATA1, a1[8*k +: 8]);
            rd(4'h4, `SCAR_ADDR_INDEX, rb);
            chk(48'(rb), 48'(idx_img(1'b0, 3'h0, 1'b0, 3'((k + 1) % 6))));
        end
        wr(4'h4, `SCAR_ADDR_INDEX, 8'h08);
        repeat (2) @(negedge sys_clk);
        chk(loc1, a1);
        chk(48'(location_valid), 48'h1);
        // A protected location keeps its bytes and index.
        wr(4'h5, `SCAR_ADDR_DATA1, ~a1[7:0]);
        rd(4'h4, `SCAR_ADDR_INDEX, rb);
        chk(48'(rb), 48'(idx_img(1'b0, 3'h0, 1'b1, 3'h0)));
        chk(loc1, a1);
        for (k = 0; k < 6; k++) begin
            rd(pg[k % 4], `SCAR_ADDR_DATA1, rb);
            chk(48'(rb), 48'(a1[8*k +: 8]));
        end
        // Learning fills location two, since location one is valid.
        wr(4'h4, `SCAR_ADDR_CFG, 8'h01);
        rd(4'h6, `SCAR_ADDR_CFG, rb);
        chk(48'(rb), 48'h01);
        chk(48'(learn_enable), 48'h1);
        for (k = 0; k < 6; k++) begin
            lrn(a2[8*k +: 8]);
            if (k == 2) begin
                rd(4'h8, `SCAR_ADDR_INDEX, rb);
                chk(48'(rb), 48'(idx_img(1'b0, 3'h3, 1'b1, 3'h0)));
            end
        end
        wr(4'h9, `SCAR_ADDR_INDEX, 8'h88);
        repeat (2) @(negedge sys_clk);
        chk(loc2, a2);
        // Both locations valid: a further learned byte is refused.
        lrn(~a2[7:0]);
        rd(4'h4, `SCAR_ADDR_INDEX, rb);
        chk(48'(rb), 48'(idx_img(1'b1, 3'h0, 1'b1, 3'h0)));
        repeat (2) @(negedge sys_clk);
        chk(loc2, a2);
        // Shared valid bits, with an unmapped write and read among them.
        for (k = 0; k < 4; k++) begin
            wr(4'h9, 8'(`SCAR_ADDR_SV1 + k), sv[8*k +: 8]);
            rd(4'h9, 8'(`SCAR_ADDR_SV1 + k), rb);
            chk(48'(rb), 48'(sv[8*k +: 8]));
        end
        wr(4'h4, `SCAR_ADDR_SV1, 8'h00);
        rd(4'h7, `SCAR_ADDR_INDEX, rb);
        chk(48'(rb), 48'h0);
        rd(4'h9, `SCAR_ADDR_SV1, rb);
        chk(48'(rb), 48'(sv[7:0]));
        chk(48'(shared_include), 48'h0);
        wr(4'h5, `SCAR_ADDR_CFG, 8'h02);
        repeat (2) @(negedge sys_clk);
        chk(48'(shared_include), 48'(sv));
        chk(48'(security_enable), 48'h1);
        wr(4'h8, `SCAR_ADDR_CFG, 8'h00);
        repeat (2) @(negedge sys_clk);
        chk(48'(shared_include), 48'h0);
        complete_run;
    end
endmodule
`default_nettype wire

/* File: rtl/scar_bank.v */
// Register bank for loading and validating security station-address locations.
`timescale 1ns/100ps
`default_nettype none
`include "scar_consts.vh"

// Overview of operation
// - Each stored byte advances location's byte index.
// - Index reads back the next byte accessed.
// - Index register readable any time during learning.
// - Bits 2..0 index, bit 3 valid, location one.
// - Bits 6..4 index, bit 7 valid, location two.
// - Byte-wide data register; six accesses per address.
// - Accesses go least significant byte first.
// - Valid shared entries join comparison under security.
// - Four registers hold thirty-two shared valid bits.
// - Shared valid registers at page 9, 16H..19H.
// - Data register decoded on pages 5,6,8,9.
// - Learn enable bit switches private learning.
// - Security enable bit switches address checking.
module scar_bank (
    input  wire        sys_clk,        // Core clock, 10 MHz.
    input  wire        sys_rst,        // Synchronous reset, active high.
    input  wire        clk_en,         // Freezes all state while low.
    input  wire [3:0]  reg_page,       // Register page select.
    input  wire [7:0]  reg_addr,       // Register address within the page.
    input  wire [7:0]  reg_wdata,      // Write data.
    input  wire        reg_write,      // One-cycle write strobe.
    input  wire        reg_read,       // One-cycle read strobe.
    input  wire        learn_strobe,   // One learned address byte is offered.
    input  wire [7:0]  learn_byte,     // The learned byte.
    output reg  [7:0]  reg_rdata,      // Read data, valid the cycle after a read.
    output reg         learn_enable,   // Private learning switched on.
    output reg         security_enable, // Address checking switched on.
    output reg  [31:0] shared_include, // Shared entries used in comparison.
    output reg  [47:0] location1_addr, // Location one address when valid.
    output reg  [47:0] location2_addr, // Location two address when valid.
    output reg  [1:0]  location_valid  // Valid flags of both locations.
);

    // ****************************************************************
    // Address decode
    // ****************************************************************
    wire       page_index_ok;     // Page carries the index and config registers.
    wire       page_data_ok;      // Page carries the data register.
    wire       page_shared_ok;    // Page carries the shared valid registers.
    wire       hit_index;         // Index register selected.
    wire       hit_data1;         // Location one data selected.
    wire       hit_data2;         // Location two data selected.
    wire       hit_cfg;           // Configuration register selected.
    wire [3:0] hit_shared;        // Shared valid register selected, one-hot.

    // The data register sits on four pages. The index and configuration registers
    // sit on those same pages and on page four as well, so software can watch a
    // location's progress from the page it uses for configuration.
    assign page_data_ok = (reg_page == `SCAR_PAGE_5) | (reg_page == `SCAR_PAGE_6) |
                          (reg_page == `SCAR_PAGE_8) | (reg_page == `SCAR_PAGE_9);
    assign page_index_ok = page_data_ok | (reg_page == `SCAR_PAGE_4);
    assign page_shared_ok = (reg_page == `SCAR_PAGE_9);
    // One select line per register. No two registers share an address, so at
    // most one select is high in any cycle and the read mux needs no priority.
    assign hit_index = page_index_ok & (reg_addr == `SCAR_ADDR_INDEX);
    assign hit_cfg   = page_index_ok & (reg_addr == `SCAR_ADDR_CFG);
    assign hit_data1 = page_data_ok & (reg_addr == `SCAR_ADDR_DATA1);
    assign hit_data2 = page_data_ok & (reg_addr == `SCAR_ADDR_DATA2);
    // One shared valid register per group of eight entries, on page nine only.
    assign hit_shared[0] = page_shared_ok & (reg_addr == `SCAR_ADDR_SV1);
    assign hit_shared[1] = page_shared_ok & (reg_addr == `SCAR_ADDR_SV2);
    assign hit_shared[2] = page_shared_ok & (reg_addr == `SCAR_ADDR_SV3);
    assign hit_shared[3] = page_shared_ok & (reg_addr == `SCAR_ADDR_SV4);

    // ****************************************************************
    // Private locations
    // ****************************************************************
    wire [2:0]  idx1;             // Location one byte index.
    wire [2:0]  idx2;             // Location two byte index.
    wire        val1;             // Location one valid flag.
    wire        val2;             // Location two valid flag.
    wire [7:0]  rbyte1;           // Location one current byte.
    wire [7:0]  rbyte2;           // Location two current byte.
    wire [47:0] addr1;            // Location one stored address.
    wire [47:0] addr2;            // Location two stored address.
    wire        learn1;           // Learned byte goes to location one.
    wire        learn2;           // Learned byte goes to location two.
    wire        index_write;      // Index register written.

    // Learning fills location one first, then location two once one is valid.
    assign learn1 = learn_strobe & learn_enable & ~val1;
    assign learn2 = learn_strobe & learn_enable & val1 & ~val2;
    // An index register write loads both valid flags together; the index bits
    // themselves are read-only, so software must read the register first.
    assign index_write = reg_write & hit_index;

    // Location one. A learned byte wins over a processor byte in the same cycle,
    // and the index then steps once only. Each stored byte steps the index.
    // Processor reads step the index as well, so six reads return the address.
    scar_location u_loc1 (
        .sys_clk          (sys_clk),
        .sys_rst          (sys_rst),
        .clk_en           (clk_en),
        .byte_write       (reg_write & hit_data1),
        .byte_read        (reg_read & hit_data1),
        .learn_write      (learn1),
        .write_byte       (learn1 ? learn_byte : reg_wdata),
        .valid_write      (index_write),
        .valid_value      (reg_wdata[`SCAR_VALID1_BIT]),
        .byte_index       (idx1),
        .entry_valid_flag (val1),
        .read_byte        (rbyte1),
        .station_addr     (addr1)
    );

    // Location two. Learning only reaches it once location one is valid, so a
    // port learns its first station into location one and its second here.
    scar_location u_loc2 (
        .sys_clk          (sys_clk),
        .sys_rst          (sys_rst),
        .clk_en           (clk_en),
        .byte_write       (reg_write & hit_data2),
        .byte_read        (reg_read & hit_data2),
        .learn_write      (learn2),
        .write_byte       (learn2 ? learn_byte : reg_wdata),
        .valid_write      (index_write),
        .valid_value      (reg_wdata[`SCAR_VALID2_BIT]),
        .byte_index       (idx2),
        .entry_valid_flag (val2),
        .read_byte        (rbyte2),
        .station_addr     (addr2)
    );

    // ****************************************************************
    // Shared valid bits and configuration
    // ****************************************************************
    reg  [31:0] shared_entry_valid_bank; // Bit n of register k is entry 8k+n+1.
    reg  [7:0]  next_rdata;              // Read mux output.

    // Shared valid registers and the configuration bits.
    // Each shared register is written whole: a write clears any bit not set in
    // the written byte, which is why software reads the register first.
    // Nothing here moves while the clock enable is low.
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            shared_entry_valid_bank <= `SCAR_VEC_ZERO;
            learn_enable            <= 1'b0;
            security_enable         <= 1'b0;
        end else if (clk_en && reg_write) begin
            if (hit_shared[0]) begin
                shared_entry_valid_bank[7:0] <= reg_wdata;
            end
            if (hit_shared[1]) begin
                shared_entry_valid_bank[15:8] <= reg_wdata;
            end
            if (hit_shared[2]) begin
                shared_entry_valid_bank[23:16] <= reg_wdata;
            end
            if (hit_shared[3]) begin
                shared_entry_valid_bank[31:24] <= reg_wdata;
            end
            if (hit_cfg) begin
                learn_enable    <= reg_wdata[`SCAR_LEARN_BIT];
                security_enable <= reg_wdata[`SCAR_SEC_BIT];
            end
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    // Selects the read byte; unmapped addresses read zero.
    // The mux looks at the state before the access, so a data read returns the
    // byte at the index as it stood, and the step happens at the same edge.
    // A read and a write in the same cycle both act; the read sees the old value.
    always @* begin
        next_rdata = `SCAR_BYTE_ZERO;
        if (hit_index) begin
            // Readable at any time, learning or not.
            next_rdata[`SCAR_IDX1_HI:`SCAR_IDX1_LO] = idx1;
            next_rdata[`SCAR_VALID1_BIT] = val1;
            next_rdata[`SCAR_IDX2_HI:`SCAR_IDX2_LO] = idx2;
            next_rdata[`SCAR_VALID2_BIT] = val2;
        end else if (hit_data1) begin
            next_rdata = rbyte1;
        end else if (hit_data2) begin
            next_rdata = rbyte2;
        end else if (hit_cfg) begin
            // Only the learn and security bits exist here; the rest read zero.
            next_rdata[`SCAR_LEARN_BIT] = learn_enable;
            next_rdata[`SCAR_SEC_BIT] = security_enable;
        end else if (hit_shared[0]) begin
            next_rdata = shared_entry_valid_bank[7:0];
        end else if (hit_shared[1]) begin
            next_rdata = shared_entry_valid_bank[15:8];
        end else if (hit_shared[2]) begin
            next_rdata = shared_entry_valid_bank[23:16];
        end else if (hit_shared[3]) begin
            next_rdata = shared_entry_valid_bank[31:24];
        end
    end

    // Registered outputs: read data, comparison enables and location images.
    // Every output comes from a flip-flop, so each image lags the state behind
    // it by one cycle. Read data only changes on a read and holds otherwise.
    // A location shows zero until its valid flag is set, so a half-loaded
    // address never reaches the comparison logic.
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            reg_rdata      <= `SCAR_BYTE_ZERO;
            shared_include <= `SCAR_VEC_ZERO;
            location1_addr <= `SCAR_ADDR_ZERO;
            location2_addr <= `SCAR_ADDR_ZERO;
            location_valid <= 2'h0;
        end else if (clk_en) begin
            if (reg_read) begin
                reg_rdata <= next_rdata;
            end
            // Only valid entries join comparison, and only under security.
            shared_include <= security_enable ? shared_entry_valid_bank : `SCAR_VEC_ZERO;
            location1_addr <= val1 ? addr1 : `SCAR_ADDR_ZERO;
            location2_addr <= val2 ? addr2 : `SCAR_ADDR_ZERO;
            location_valid <= {val2, val1};
        end
    end

endmodule
`default_nettype wire

/* File: rtl/scar_consts.vh */
// Constants for the security CAM address register bank.
`ifndef SCAR_CONSTS_VH
`define SCAR_CONSTS_VH
// Register pages.
`define SCAR_PAGE_4      4'h4
`define SCAR_PAGE_5      4'h5
`define SCAR_PAGE_6      4'h6
`define SCAR_PAGE_8      4'h8
`define SCAR_PAGE_9      4'h9
// Register addresses within a page.
`define SCAR_ADDR_SV1    8'h16
`define SCAR_ADDR_SV2    8'h17
`define SCAR_ADDR_SV3    8'h18
`define SCAR_ADDR_SV4    8'h19
`define SCAR_ADDR_INDEX  8'h1a
`define SCAR_ADDR_DATA1  8'h1b
`define SCAR_ADDR_DATA2  8'h1c
`define SCAR_ADDR_CFG    8'h1d
// Byte index register fields.
`define SCAR_IDX1_LO     0
`define SCAR_IDX1_HI     2
`define SCAR_VALID1_BIT  3
`define SCAR_IDX2_LO     4
`define SCAR_IDX2_HI     6
`define SCAR_VALID2_BIT  7
// Configuration register fields.
`define SCAR_LEARN_BIT   0
`define SCAR_SEC_BIT     1
// Byte index limits and reset values.
`define SCAR_IDX_LAST    3'h5
`define SCAR_IDX_FIRST   3'h0
`define SCAR_BYTE_ZERO   8'h00
`define SCAR_ADDR_ZERO   48'h000000000000
`define SCAR_VEC_ZERO    32'h00000000
`endif

/* File: rtl/scar_location.v */
// One private station-address location: six bytes, a byte index and a valid flag.
`timescale 1ns/100ps
`default_nettype none
`include "scar_consts.vh"

module scar_location (
    input  wire        sys_clk,      // Core clock.
    input  wire        sys_rst,      // Synchronous reset, active high.
    input  wire        clk_en,       // Freezes all state while low.
    input  wire        byte_write,   // Processor writes one byte.
    input  wire        byte_read,    // Processor reads one byte.
    input  wire        learn_write,  // Learning engine captures one byte.
    input  wire [7:0]  write_byte,   // Byte to store.
    input  wire        valid_write,  // Load the valid flag.
    input  wire        valid_value,  // New valid flag.
    output reg  [2:0]  byte_index,   // Byte that the next access uses.
    output reg         entry_valid_flag, // Entry protected and usable.
    output wire [7:0]  read_byte,    // Byte at the current index.
    output wire [47:0] station_addr  // Whole stored address.
);

    // ****************************************************************
    // Storage
    // ****************************************************************
    reg  [7:0] addr_byte [0:5];   // Address bytes, least significant first.
    wire       store;             // A byte is stored this cycle.
    wire       step;              // The index moves this cycle.
    wire [2:0] next_byte_index;   // Index after a step.
    integer    i;                 // Loop index for reset.

    // A valid entry refuses stores; only reads then step its index.
    assign store = (byte_write | learn_write) & ~entry_valid_flag;
    // Reads always step so that six reads return the whole address.
    assign step = store | byte_read;
    // The index wraps after the sixth byte.
    assign next_byte_index = (byte_index == `SCAR_IDX_LAST) ? `SCAR_IDX_FIRST
                                                            : byte_index + 3'h1;
    assign read_byte = addr_byte[byte_index];
    assign station_addr = {addr_byte[5], addr_byte[4], addr_byte[3],
                           addr_byte[2], addr_byte[1], addr_byte[0]};

    // Bytes, index and flag update together.
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            byte_index       <= `SCAR_IDX_FIRST;
            entry_valid_flag <= 1'b0;
            for (i = 0; i < 6; i = i + 1) begin
                addr_byte[i] <= `SCAR_BYTE_ZERO;
            end
        end else if (clk_en) begin
            if (store) begin
                addr_byte[byte_index] <= write_byte;
            end
            if (step) begin
                byte_index <= next_byte_index;
            end
            if (valid_write) begin
                entry_valid_flag <= valid_value;
            end
        end
    end

endmodule
`default_nettype wire
